// [adsq_afe_model.sv]
// Behavioural analog front end: six channel levels, a sample-hold and a ladder comparator.
// Assumes the control block pulses sample for one cycle and holds the trial code steady within a step.
`timescale 1ns/1ps

module adsq_afe_model
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Control from the block, and the six channel levels
  input wire logic sample_i,
  input wire logic ladder_on_i,
  input wire logic [3:0] channel_i,
  input wire logic [9:0] dac_code_i,
  input wire logic [9:0] level_i [6],
  // Decision to the block
  output logic cmp_high_o
);
  logic [9:0] held_q;
  logic noise_q;

  // A reserved channel leaves the hold capacitor at a junk level rather than a clean zero.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      held_q <= 10'h000;
    else if (sample_i)
      held_q <= (channel_i <= 4'h5) ? level_i[channel_i[2:0]] : ~held_q;
  end

  always_ff @(posedge clk_i)
  begin
    noise_q <= srst_i ? 1'b0 : ~noise_q;
  end

  // Without the ladder there is no reference, so the decision is worthless and keeps changing.
  assign cmp_high_o = ladder_on_i ? (held_q >= dac_code_i) : noise_q;
endmodule // adsq_afe_model

// [adsq_ctrl.sv]
// Converter control block: control and result registers, start and repeat sequencing, standby handling.
// Assumes a byte register port with read data one cycle after the read strobe, and an analog front end.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "adsq_defines.svh"

// Operation
// - Ten-bit result split high and low registers.
// - Done flag reads one after completion.
// - Busy set on start, cleared finish/standby.
// - Reading high result clears done flag.
// - Status bits three to zero undefined.
// - Mode 01 start bit begins one conversion.
// - Completion loads result, sets done, interrupts.
// - Start bit clears itself once begun.
// - Repeat mode restarts after each completion.
// - Mode 00 stops at once, no store.
// - New start clears done, keeps old result.
// - Standby aborts and initialises control registers.
// - No automatic restart after leaving standby.
// - Ladder disconnected throughout standby.
// - Control one holds start, mode, disable, channel.
// - Time field picks 39 to 1248 clocks.
// - Control registers held and unwritable in standby.
// - Ladder bit: during conversion or always.
module adsq_ctrl
  import adsq_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Power mode
  input wire logic standby_i,
  // Analog front end
  input wire logic cmp_high_i,
  output logic [9:0] dac_code_o,
  output logic [3:0] channel_select_o,
  output logic analog_input_disable_o,
  output logic sample_o,
  output logic ladder_on_o,
  // Interrupt request
  output logic conv_done_irq_o
);
  adsq_state_type state_q;
  logic [7:0] ctrl_one_q;
  logic [7:0] ctrl_two_q;
  logic [9:0] result_q;
  logic done_flag_q;
  logic busy_q;
  logic sar_done;
  logic [9:0] sar_result;
  logic [10:0] total_cycles;
  logic [1:0] conv_op_mode;
  logic conv_start_bit;
  logic start_now;
  logic abort_now;
  logic wr_one;
  logic wr_two;
  logic rd_high;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  function automatic logic [10:0] cycles_of(input logic [2:0] code);
    case (code)
      `ADSQ_TIME_39: cycles_of = `ADSQ_CYC_39;
      `ADSQ_TIME_78: cycles_of = `ADSQ_CYC_78;
      `ADSQ_TIME_156: cycles_of = `ADSQ_CYC_156;
      `ADSQ_TIME_312: cycles_of = `ADSQ_CYC_312;
      `ADSQ_TIME_624: cycles_of = `ADSQ_CYC_624;
      `ADSQ_TIME_1248: cycles_of = `ADSQ_CYC_1248;
      // Reserved codes fall back to the longest time, the safest for accuracy.
      default: cycles_of = `ADSQ_CYC_1248;
    endcase
  endfunction

  assign conv_op_mode = ctrl_one_q[`ADSQ_C1_MODE_HI:`ADSQ_C1_MODE_LO];
  assign conv_start_bit = ctrl_one_q[`ADSQ_C1_START];
  assign total_cycles = cycles_of(ctrl_two_q[`ADSQ_C2_TIME_HI:`ADSQ_C2_TIME_LO]);
  assign wr_one = reg_wr_i && hit(reg_addr_i, `ADSQ_OFS_CTRL_ONE) && !standby_i;
  assign wr_two = reg_wr_i && hit(reg_addr_i, `ADSQ_OFS_CTRL_TWO) && !standby_i;
  assign rd_high = reg_rd_i && hit(reg_addr_i, `ADSQ_OFS_RES_HIGH);

  // Start only from idle; software mode and repeat mode both need the start bit.
  assign start_now = !standby_i && (state_q == ADSQ_IDLE) && conv_start_bit &&
                     (conv_op_mode == `ADSQ_MODE_SW || conv_op_mode == `ADSQ_MODE_REPEAT);
  // Mode off or standby kills a conversion mid-way without storing it.
  assign abort_now = standby_i || (conv_op_mode == `ADSQ_MODE_OFF);

  always_ff @(posedge clk_i)
  begin
    if (srst_i || standby_i)
    begin
      ctrl_one_q <= `ADSQ_C1_RESET;
    end
    else if (wr_one)
    begin
      ctrl_one_q <= reg_wdata_i;
    end
    else if (state_q == ADSQ_SAMPLE)
    begin
      ctrl_one_q[`ADSQ_C1_START] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i || standby_i)
    begin
      ctrl_two_q <= `ADSQ_C2_RESET;
    end
    else if (wr_two)
    begin
      ctrl_two_q <= reg_wdata_i;
    end
  end

  // Sequencer: sample for one cycle, let the SAR walk, then finish or rearm.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_q <= ADSQ_IDLE;
    end
    else if (abort_now)
    begin
      state_q <= ADSQ_IDLE;
    end
    else
    begin
      case (state_q)
        ADSQ_IDLE: if (start_now) state_q <= ADSQ_SAMPLE;
        ADSQ_SAMPLE: state_q <= ADSQ_STEP;
        ADSQ_STEP: if (sar_done) state_q <= ADSQ_FINISH;
        // Repeat mode rearms straight away without a new start bit.
        ADSQ_FINISH: state_q <= (conv_op_mode == `ADSQ_MODE_REPEAT) ? ADSQ_SAMPLE : ADSQ_IDLE;
        default: state_q <= ADSQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i || abort_now)
    begin
      busy_q <= 1'b0;
    end
    else if (start_now)
    begin
      busy_q <= 1'b1;
    end
    // Cleared at the completion edge itself so that busy and done never overlap in software mode.
    else if (state_q == ADSQ_STEP && sar_done && !abort_now && conv_op_mode != `ADSQ_MODE_REPEAT)
    begin
      busy_q <= 1'b0;
    end
  end

  // Completion wins over a same-cycle read of the high result.
  always_ff @(posedge clk_i)
  begin
    if (srst_i || standby_i)
    begin
      done_flag_q <= 1'b0;
    end
    else if (state_q == ADSQ_STEP && sar_done && !abort_now)
    begin
      done_flag_q <= 1'b1;
    end
    else if (start_now || state_q == ADSQ_SAMPLE)
    begin
      done_flag_q <= 1'b0;
    end
    else if (rd_high)
    begin
      done_flag_q <= 1'b0;
    end
  end

  // Result holds until the next completion; standby leaves it undefined, here cleared.
  always_ff @(posedge clk_i)
  begin
    if (srst_i || standby_i)
    begin
      result_q <= 10'h000;
    end
    else if (state_q == ADSQ_STEP && sar_done && !abort_now)
    begin
      result_q <= sar_result;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      conv_done_irq_o <= 1'b0;
    end
    else
    begin
      conv_done_irq_o <= state_q == ADSQ_STEP && sar_done && !abort_now;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `ADSQ_OFS_RES_HIGH: reg_rdata_o <= result_q[9:2];
        // Low four bits are undefined; zero is returned.
        `ADSQ_OFS_RES_LOW: reg_rdata_o <= {result_q[1:0], done_flag_q, busy_q, 4'h0};
        `ADSQ_OFS_CTRL_ONE: reg_rdata_o <= ctrl_one_q;
        `ADSQ_OFS_CTRL_TWO: reg_rdata_o <= {2'h0, ctrl_two_q[5:0]};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
    else
    begin
      reg_rdata_o <= 8'h00;
    end
  end

  assign channel_select_o = ctrl_one_q[`ADSQ_C1_CH_HI:`ADSQ_C1_CH_LO];
  assign analog_input_disable_o = ctrl_one_q[`ADSQ_C1_INDIS];
  assign sample_o = (state_q == ADSQ_SAMPLE);
  // Ladder off in standby, otherwise always or only while busy.
  assign ladder_on_o = !standby_i && (ctrl_two_q[`ADSQ_C2_LADDER] || busy_q);

  adsq_sar u_sar (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .go_i(state_q == ADSQ_SAMPLE && !abort_now),
    .abort_i(abort_now),
    .total_cycles_i(total_cycles),
    .cmp_high_i(cmp_high_i),
    .dac_code_o(dac_code_o),
    .done_o(sar_done),
    .result_o(sar_result)
  );

  sequence s_start;
    start_now;
  endsequence
  sequence s_begun;
    ##1 (state_q == ADSQ_SAMPLE && busy_q) ##1 !conv_start_bit;
  endsequence

  AST_START_SEQ: assert property (@(posedge clk_i) disable iff (srst_i)
    s_start |-> s_begun or (##[1:2] abort_now)) else $error("Start did not begin.");
  AST_START_CLEAR: assert property (@(posedge clk_i) disable iff (srst_i)
    (state_q == ADSQ_SAMPLE && !wr_one && !standby_i) |=> !conv_start_bit)
    else $error("Start bit not cleared.");
  AST_BUSY_STBY: assert property (@(posedge clk_i) disable iff (srst_i)
    standby_i |=> !busy_q && ctrl_one_q == `ADSQ_C1_RESET) else $error("Standby did not reset.");
  AST_DONE_SET: assert property (@(posedge clk_i) disable iff (srst_i)
    conv_done_irq_o |-> done_flag_q && result_q == $past(sar_result)) else $error("Done not set.");
  AST_RD_CLEAR: assert property (@(posedge clk_i) disable iff (srst_i)
    (rd_high && !(state_q == ADSQ_STEP && sar_done)) |=> !done_flag_q) else $error("Read did not clear.");
  AST_NOT_BOTH: assert property (@(posedge clk_i) disable iff (srst_i)
    !(busy_q && done_flag_q && conv_op_mode == `ADSQ_MODE_SW)) else $error("Busy and done both set.");
  AST_MODE_OFF: assert property (@(posedge clk_i) disable iff (srst_i)
    (conv_op_mode == `ADSQ_MODE_OFF && state_q == ADSQ_STEP) |=> $stable(result_q))
    else $error("Aborted value stored.");
  AST_LADDER: assert property (@(posedge clk_i) disable iff (srst_i)
    standby_i |-> !ladder_on_o) else $error("Ladder on in standby.");
  AST_RDATA: assert property (@(posedge clk_i) disable iff (srst_i)
    (reg_rd_i && reg_addr_i == `ADSQ_OFS_RES_HIGH) |=> reg_rdata_o == $past(result_q[9:2]))
    else $error("High read wrong.");
  AST_REPEAT: assert property (@(posedge clk_i) disable iff (srst_i)
    (state_q == ADSQ_FINISH && conv_op_mode == `ADSQ_MODE_REPEAT && !standby_i) |=> state_q == ADSQ_SAMPLE)
    else $error("Repeat did not rearm.");

  // A completion that is not cut short by mode off or standby.
  sequence s_complete;
    state_q == ADSQ_STEP && sar_done && !abort_now;
  endsequence

  // Completion and flag handling.
  AST_DONE_LOAD: assert property (@(posedge clk_i) disable iff (srst_i)
    s_complete |=> done_flag_q && conv_done_irq_o)
    else $error("Completion did not set done and request.");
  AST_IRQ_PULSE: assert property (@(posedge clk_i) disable iff (srst_i)
    conv_done_irq_o |=> !conv_done_irq_o)
    else $error("Request longer than one cycle.");
  AST_BUSY_CLEAR: assert property (@(posedge clk_i) disable iff (srst_i)
    (state_q == ADSQ_STEP && sar_done && !abort_now && conv_op_mode == `ADSQ_MODE_SW) |=> !busy_q)
    else $error("Busy kept after completion.");
  AST_BUSY_RISE: assert property (@(posedge clk_i) disable iff (srst_i)
    start_now |=> busy_q && sample_o)
    else $error("Busy not set at start.");
  AST_BUSY_REPEAT: assert property (@(posedge clk_i) disable iff (srst_i)
    (state_q == ADSQ_FINISH && conv_op_mode == `ADSQ_MODE_REPEAT && !standby_i) |=> busy_q)
    else $error("Busy dropped between repeats.");
  AST_SAMPLE_CLR: assert property (@(posedge clk_i) disable iff (srst_i)
    (state_q == ADSQ_SAMPLE && !standby_i) |=> !done_flag_q)
    else $error("New conversion kept done.");
  AST_RESULT_HOLD: assert property (@(posedge clk_i) disable iff (srst_i)
    (!(state_q == ADSQ_STEP && sar_done && !abort_now) && !standby_i) |=> $stable(result_q))
    else $error("Result changed without completion.");

  // Sequencing.
  AST_SW_ONCE: assert property (@(posedge clk_i) disable iff (srst_i)
    (state_q == ADSQ_FINISH && conv_op_mode == `ADSQ_MODE_SW && !standby_i) |=> state_q == ADSQ_IDLE)
    else $error("Software mode converted twice.");
  AST_NO_RESTART: assert property (@(posedge clk_i) disable iff (srst_i)
    (state_q == ADSQ_IDLE && !conv_start_bit) |=> state_q == ADSQ_IDLE)
    else $error("Conversion began without start.");
  AST_MODE_OFF_IDLE: assert property (@(posedge clk_i) disable iff (srst_i)
    (conv_op_mode == `ADSQ_MODE_OFF) |=> state_q == ADSQ_IDLE && !busy_q)
    else $error("Mode off did not stop.");

  // Standby, ladder and register port.
  AST_STBY_CLEAR: assert property (@(posedge clk_i) disable iff (srst_i)
    standby_i |=> !done_flag_q && result_q == 10'h000)
    else $error("Standby kept the result.");
  AST_CTRL2_STBY: assert property (@(posedge clk_i) disable iff (srst_i)
    standby_i |=> ctrl_two_q == `ADSQ_C2_RESET)
    else $error("Control two written in standby.");
  AST_LADDER_RUN: assert property (@(posedge clk_i) disable iff (srst_i)
    (state_q == ADSQ_STEP && !standby_i) |-> ladder_on_o)
    else $error("Ladder off during conversion.");
  AST_LOW_READ: assert property (@(posedge clk_i) disable iff (srst_i)
    (reg_rd_i && reg_addr_i == `ADSQ_OFS_RES_LOW) |=> reg_rdata_o == {$past(result_q[1:0]), $past(done_flag_q), $past(busy_q), 4'h0})
    else $error("Low read wrong.");
  AST_IDLE_RDATA: assert property (@(posedge clk_i) disable iff (srst_i)
    !reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("Read data stood too long.");
endmodule // adsq_ctrl

// [adsq_defines.svh]
// Register offsets, field positions, reset values and timing counts of the converter control block.
// Assumes a byte-wide register port with offsets decoded on the low eight address bits.
`ifndef ADSQ_DEFINES_SVH
`define ADSQ_DEFINES_SVH

`define ADSQ_OFS_RES_LOW 8'h20
`define ADSQ_OFS_RES_HIGH 8'h21
`define ADSQ_OFS_CTRL_ONE 8'h0E
`define ADSQ_OFS_CTRL_TWO 8'h0F

`define ADSQ_C1_START 7
`define ADSQ_C1_MODE_HI 6
`define ADSQ_C1_MODE_LO 5
`define ADSQ_C1_INDIS 4
`define ADSQ_C1_CH_HI 3
`define ADSQ_C1_CH_LO 0
`define ADSQ_C2_LADDER 5
`define ADSQ_C2_TIME_HI 3
`define ADSQ_C2_TIME_LO 1
`define ADSQ_C2_FIXED_ONE 4
`define ADSQ_ST_DONE 5
`define ADSQ_ST_BUSY 4

`define ADSQ_C1_RESET 8'h10
`define ADSQ_C2_RESET 8'h10
`define ADSQ_CH_MAX 4'h5

`define ADSQ_MODE_OFF 2'h0
`define ADSQ_MODE_SW 2'h1
`define ADSQ_MODE_REPEAT 2'h3

`define ADSQ_TIME_39 3'h0
`define ADSQ_TIME_78 3'h2
`define ADSQ_TIME_156 3'h3
`define ADSQ_TIME_312 3'h4
`define ADSQ_TIME_624 3'h5
`define ADSQ_TIME_1248 3'h6
`define ADSQ_CYC_39 11'h027
`define ADSQ_CYC_78 11'h04E
`define ADSQ_CYC_156 11'h09C
`define ADSQ_CYC_312 11'h138
`define ADSQ_CYC_624 11'h270
`define ADSQ_CYC_1248 11'h4E0
`define ADSQ_SAR_BITS 10
`define ADSQ_SAR_LAST 4'h9

`endif

// [adsq_pkg.sv]
// Types shared by the converter control block.
// Assumes the defines header is compiled alongside.
package adsq_pkg;
  typedef enum logic [1:0] {ADSQ_IDLE, ADSQ_SAMPLE, ADSQ_STEP, ADSQ_FINISH} adsq_state_type;
endpackage

// [adsq_sar.sv]
// Successive-approximation stepper: one trial bit per step from the MSB, paced over the conversion time.
// Assumes a comparator that answers combinationally to the trial code on dac_code_o.
`timescale 1ns/1ps
`include "adsq_defines.svh"

module adsq_sar
  import adsq_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Control
  input wire logic go_i,
  input wire logic abort_i,
  input wire logic [10:0] total_cycles_i,
  // Comparator
  input wire logic cmp_high_i,
  output logic [9:0] dac_code_o,
  // Result
  output logic done_o,
  output logic [9:0] result_o
);
  logic [10:0] cnt_q;
  logic [10:0] step_len_q;
  logic [3:0] bit_q;
  logic [9:0] sar_q;
  logic run_q;
  logic step_en;

  // Steps are spread evenly; the remainder of the division is dropped, so the conversion ends that many cycles early.
  assign step_en = run_q && (cnt_q == step_len_q);
  assign dac_code_o = sar_q;

  always_ff @(posedge clk_i)
  begin
    if (srst_i || abort_i)
    begin
      run_q <= 1'b0;
      cnt_q <= 11'h000;
      step_len_q <= 11'h001;
      bit_q <= 4'h0;
      sar_q <= 10'h000;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (go_i)
      begin
        run_q <= 1'b1;
        cnt_q <= 11'h001;
        step_len_q <= 11'(total_cycles_i / 11'(`ADSQ_SAR_BITS));
        bit_q <= 4'h0;
        sar_q <= 10'h200;
      end
      else if (run_q)
      begin
        cnt_q <= step_en ? 11'h001 : 11'(cnt_q + 11'h001);
        if (step_en)
        begin
          // Keep or drop the trial bit, then try the next lower one.
          if (!cmp_high_i)
            sar_q[4'(`ADSQ_SAR_LAST - bit_q)] <= 1'b0;
          if (bit_q == `ADSQ_SAR_LAST)
          begin
            run_q <= 1'b0;
            done_o <= 1'b1;
            result_o <= cmp_high_i ? sar_q : {sar_q[9:1], 1'b0};
          end
          else
          begin
            bit_q <= 4'(bit_q + 4'h1);
            sar_q[4'(`ADSQ_SAR_LAST - bit_q - 4'h1)] <= 1'b1;
          end
        end
      end
    end
  end

  AST_DONE_PULSE: assert property (@(posedge clk_i) disable iff (srst_i)
    done_o |=> !done_o) else $error("Done is longer than one cycle.");
  AST_SAR_MSB: assert property (@(posedge clk_i) disable iff (srst_i)
    (go_i && !abort_i) |=> dac_code_o == 10'h200) else $error("First trial is not the top bit.");
endmodule // adsq_sar

// [tb.sv]
// Self-checking bench for the converter control block against a behavioural analog front end.
// Assumes the register map of the defines header and a 50 MHz clock.
`timescale 1ns/1ps
`include "adsq_defines.svh"

module tb;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic standby_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic cmp_high_i;
  logic [9:0] dac_code_o;
  logic [3:0] channel_select_o;
  logic analog_input_disable_o;
  logic sample_o;
  logic ladder_on_o;
  logic conv_done_irq_o;
  logic [9:0] level [6];
  logic [7:0] rd;
  logic [3:0] cur_ch;
  int fail_count = 0;
  int n_compared = 0;
  int cyc_cnt = 0;
  int prev_res = 0;
  int exp_res = 0;
  int n_exp = 0;
  bit rep = 1'b0;
  int conv_cycles [8] = '{39, 1248, 78, 156, 312, 624, 1248, 1248};

  always #10 clk_i = ~clk_i;

  adsq_ctrl i_adsq_ctrl (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .standby_i(standby_i),
    .cmp_high_i(cmp_high_i), .dac_code_o(dac_code_o), .channel_select_o(channel_select_o),
    .analog_input_disable_o(analog_input_disable_o), .sample_o(sample_o), .ladder_on_o(ladder_on_o),
    .conv_done_irq_o(conv_done_irq_o));

  adsq_afe_model i_adsq_afe_model (.clk_i(clk_i), .srst_i(srst_i), .sample_i(sample_o),
    .ladder_on_i(ladder_on_o), .channel_i(channel_select_o), .dac_code_i(dac_code_o), .level_i(level),
    .cmp_high_o(cmp_high_i));

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    rd = reg_rdata_o;
  endtask

  // Programs channel, mode and time, then starts, and checks the block while it converts.
  task automatic start_conv(input logic [1:0] mode, input logic [2:0] tc, input logic lad);
    cur_ch = 4'($urandom % 6);
    @(posedge clk_i);
    level[cur_ch] <= 10'($urandom);
    rep = (mode == `ADSQ_MODE_REPEAT);
    n_exp = conv_cycles[tc];
    wreg(`ADSQ_OFS_CTRL_ONE, {1'b0, mode, 1'b0, cur_ch});
    wreg(`ADSQ_OFS_CTRL_TWO, {2'b00, lad, 1'b1, tc, 1'b0});
    wreg(`ADSQ_OFS_CTRL_ONE, {1'b1, mode, 1'b0, cur_ch});
    exp_res = int'(level[cur_ch]);
    rreg(`ADSQ_OFS_RES_HIGH);
    check("held_high", 10'(prev_res >> 2), 10'(rd));
    rreg(`ADSQ_OFS_RES_LOW);
    check("status_run", 10'({prev_res[1:0], 2'b01}), 10'(rd[7:4]));
    rreg(`ADSQ_OFS_CTRL_ONE);
    check("start_bit", 10'h000, 10'(rd[7]));
    check("channel", 10'(cur_ch), 10'(channel_select_o));
    check("input_disable", 10'h000, 10'(analog_input_disable_o));
    check("ladder_run", 10'h001, 10'(ladder_on_o));
  endtask

  task automatic finish_conv(input bit rd_high);
    int n;
    n = 0;
    while (conv_done_irq_o !== 1'b1 && n < 1400)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check("irq", 10'h001, 10'(conv_done_irq_o));
    if (!rep)
      check("conv_time", 10'h001, 10'(n >= n_exp - 15 && n <= n_exp + 5));
    rreg(`ADSQ_OFS_RES_LOW);
    check("result_low", 10'(exp_res & 3), 10'(rd[7:6]));
    if (!rep)
      check("status_done", 10'h002, 10'(rd[5:4]));
    if (rd_high)
    begin
      rreg(`ADSQ_OFS_RES_HIGH);
      check("result_high", 10'(exp_res >> 2), 10'(rd));
      rreg(`ADSQ_OFS_RES_LOW);
      if (!rep)
        check("done_clear", 10'h000, 10'(rd[5]));
    end
    prev_res = exp_res;
  endtask

  // Watches for 200 cycles that no completion appears and the block stays idle.
  task automatic quiet(input string what);
    int k;
    k = 0;
    repeat (200)
    begin
      @(posedge clk_i);
      #1;
      k += int'(conv_done_irq_o === 1'b1);
    end
    check(what, 10'h000, 10'(k));
    rreg(`ADSQ_OFS_RES_LOW);
    check("status_idle", 10'({prev_res[1:0], 2'b00}), 10'(rd[7:4]));
  endtask

  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 40000)
    begin
      fail_count++;
      $display("Error timeout expected finished seen running");
      wrap_up();
    end
  end

  initial
  begin
    foreach (level[i])
      level[i] = 10'h000;
    void'($urandom(32'h34D1));
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    rreg(`ADSQ_OFS_CTRL_ONE);
    check("ctrl_one_reset", 10'(`ADSQ_C1_RESET), 10'(rd));
    rreg(`ADSQ_OFS_CTRL_TWO);
    check("ctrl_two_reset", 10'(`ADSQ_C2_RESET), 10'(rd));
    wreg(`ADSQ_OFS_RES_HIGH, 8'hFF);
    rreg(`ADSQ_OFS_RES_HIGH);
    check("high_reset", 10'h000, 10'(rd));
    rreg(`ADSQ_OFS_RES_LOW);
    check("low_reset", 10'h000, 10'(rd[7:4]));
    rreg(8'h33);
    check("unmapped", 10'h000, 10'(rd));
    check("disable_reset", 10'h001, 10'(analog_input_disable_o));
    check("ladder_reset", 10'h000, 10'(ladder_on_o));
    $display("test reset done");
    for (int t = 0; t < 8; t++)
    begin
      start_conv(`ADSQ_MODE_SW, 3'(t), 1'(t));
      finish_conv(bit'(t != 3));
      check("ladder_idle", 10'(t & 1), 10'(ladder_on_o));
    end
    $display("test software start done");
    start_conv(`ADSQ_MODE_REPEAT, 3'h0, 1'b0);
    finish_conv(1'b1);
    level[cur_ch] <= 10'($urandom);
    finish_conv(1'b0);
    exp_res = int'(level[cur_ch]);
    finish_conv(1'b1);
    level[cur_ch] <= 10'($urandom);
    repeat (10) @(posedge clk_i);
    wreg(`ADSQ_OFS_CTRL_ONE, {3'b000, 1'b0, cur_ch});
    quiet("irq_after_off");
    $display("test repeat done");
    start_conv(`ADSQ_MODE_SW, 3'h2, 1'b1);
    @(posedge clk_i);
    standby_i <= 1'b1;
    wreg(`ADSQ_OFS_CTRL_TWO, 8'h3C);
    rreg(`ADSQ_OFS_CTRL_ONE);
    check("ctrl_one_standby", 10'(`ADSQ_C1_RESET), 10'(rd));
    rreg(`ADSQ_OFS_CTRL_TWO);
    check("ctrl_two_standby", 10'(`ADSQ_C2_RESET), 10'(rd));
    check("ladder_standby", 10'h000, 10'(ladder_on_o));
    prev_res = 0;
    quiet("irq_standby");
    standby_i <= 1'b0;
    quiet("irq_resume");
    start_conv(`ADSQ_MODE_SW, 3'h0, 1'b0);
    finish_conv(1'b1);
    $display("test standby done");
    wrap_up();
  end
endmodule // tb
